// ---- src/lld_pkg.sv ----
// Constants for the link-layer diagnostic and error register bank.
// Assumes a 32-bit Avalon-MM slave decoding full byte addresses.
// Overview of operation
// - Six-bit select picks what drives probe lane 0, only while enabled.
// - Disabled probe port drives all eight lane 0 lines to zero.
// - Readback register shows the four live debug lanes, lane 3 on top.
// - Sixteen-bit upper and lower zone bounds, read/write, upper half reserved.
// - Bit 11 flags an invalid control-structure format, held until cleared by writing one.
// - Bit 10 flags a null transmit pointer in the control structure.
// - Bit 8 flags a late exchange-memory access by the radio controller.
// - At hop start, channel-map popcount unequal to good count sets bit 7.
// - Bit 6 flags frame-space expiry before descriptor, list or decrypt finish.
// - Bit 5 flags decryption unfinished when the frame space expires.
// - Bit 4 flags an accept-list parsing timeout.
// - Bit 3 flags three consecutive programmed exchange-table entries.
// - Bit 2 flags a fetched transmit descriptor without its done bit.
// - Bit 1 flags a late exchange-memory access by the packet controller.
// - Bit 0 flags encryption unfinished when payload transmission starts.
// - Thirty-two-bit profiling word is copied onto the diagnostic output.
package lld_pkg;
	localparam int unsigned ADDR_W = 32;
	localparam int unsigned DATA_W = 32;
	localparam logic [31:0] OFF_DIAG_CTRL  = 32'h4000_0050;
	localparam logic [31:0] OFF_DIAG_RDBK  = 32'h4000_0054;
	localparam logic [31:0] OFF_ZONE_UPPER = 32'h4000_0058;
	localparam logic [31:0] OFF_ZONE_LOWER = 32'h4000_005C;
	localparam logic [31:0] OFF_ERR_FLAGS  = 32'h4000_0060;
	localparam logic [31:0] OFF_PROFILING  = 32'h4000_0064;
	localparam logic [31:0] OFF_IRQ_STATUS = 32'h4000_0068;
	localparam logic [31:0] OFF_IRQ_MASK   = 32'h4000_006C;
	localparam logic [31:0] OFF_RADIO_CTL0 = 32'h4000_0070;
	localparam logic [31:0] OFF_RADIO_CTL1 = 32'h4000_0074;
	localparam int unsigned SEL_LSB      = 0;
	localparam int unsigned SEL_W        = 6;
	localparam int unsigned EN0_BIT      = 7;
	localparam int unsigned ZONE_W       = 16;
	localparam int unsigned ERR_W        = 12;
	localparam logic [11:0] ERR_MASK     = 12'hDFF;
	localparam int unsigned ERR_TXCRYPT  = 0;
	localparam int unsigned ERR_PKTXMEM  = 1;
	localparam int unsigned ERR_TXDESC   = 2;
	localparam int unsigned ERR_PREFETCH = 3;
	localparam int unsigned ERR_ACCLIST  = 4;
	localparam int unsigned ERR_RXCRYPT  = 5;
	localparam int unsigned ERR_IFS      = 6;
	localparam int unsigned ERR_CHMAP    = 7;
	localparam int unsigned ERR_RADXMEM  = 8;
	localparam int unsigned ERR_TXPTR    = 10;
	localparam int unsigned ERR_FORMAT   = 11;
	localparam int unsigned DCPATH_BIT   = 22;
	localparam logic [21:0] RC0_RSVD_VAL = 22'h00_2102;
	localparam int unsigned XRF_LSB      = 16;
	localparam int unsigned XRF_W        = 5;
	localparam int unsigned CHMAP_W      = 37;
	localparam int unsigned CHCNT_W      = 6;
	localparam int unsigned TXPTR_W      = 16;
	localparam logic [1:0]  PREFETCH_RUN = 2'h3;
	localparam logic [5:0]  SEL_PROF0    = 6'h00;
	localparam logic [5:0]  SEL_PROF1    = 6'h01;
	localparam logic [5:0]  SEL_PROF2    = 6'h02;
	localparam logic [5:0]  SEL_PROF3    = 6'h03;
	localparam logic [5:0]  SEL_ERR_LO   = 6'h04;
	localparam logic [5:0]  SEL_ERR_HI   = 6'h05;
	// Bus handshake phases of the slave
	typedef enum logic {BUS_IDLE, BUS_ANSWER} lld_bus_t;
endpackage

// ---- src/lld_regs.sv ----
// Diagnostic, error-status and radio-control register bank of the link layer.
// Assumes an Avalon-MM master on i_sys_clk and single-cycle event pulses
// from the link-layer engine in the same clock domain.
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/1ps
module lld_regs
#(
	parameter int unsigned CHMAP_BITS = lld_pkg::CHMAP_W
)
(
	input  wire logic                       i_sys_clk,
	input  wire logic                       i_rst_n,
	input  wire logic [lld_pkg::ADDR_W-1:0] i_address,
	input  wire logic                       i_read,
	input  wire logic                       i_write,
	input  wire logic [lld_pkg::DATA_W-1:0] i_writedata,
	input  wire logic [3:0]                 i_byteenable,
	output logic      [lld_pkg::DATA_W-1:0] o_readdata,
	output logic                            o_waitrequest,
	output logic                            o_irq,
	input  wire logic                       i_format_invalid,
	input  wire logic                       i_cs_fetch,
	input  wire logic [lld_pkg::TXPTR_W-1:0] i_control_structure_tx_pointer,
	input  wire logic                       i_radio_xmem_late,
	input  wire logic                       i_hop_start,
	input  wire logic [CHMAP_BITS-1:0]      i_control_structure_channel_map,
	input  wire logic [lld_pkg::CHCNT_W-1:0] i_good_channel_count,
	input  wire logic                       i_ifs_expired,
	input  wire logic                       i_cs_busy,
	input  wire logic                       i_accept_list_busy,
	input  wire logic                       i_decrypt_busy,
	input  wire logic                       i_accept_list_timeout,
	input  wire logic                       i_xtable_fetch,
	input  wire logic                       i_xtable_programmed,
	input  wire logic                       i_tx_desc_fetch,
	input  wire logic                       i_descriptor_done_bit,
	input  wire logic                       i_packet_xmem_late,
	input  wire logic                       i_payload_start,
	input  wire logic                       i_encrypt_busy,
	input  wire logic [7:0]                 i_debug_out_lane1,
	input  wire logic [7:0]                 i_debug_out_lane2,
	input  wire logic [7:0]                 i_debug_out_lane3,
	output logic      [7:0]                 o_debug_out_lane0,
	output logic      [lld_pkg::DATA_W-1:0] o_profiling_value,
	output logic      [lld_pkg::ZONE_W-1:0] o_zone_upper_bound,
	output logic      [lld_pkg::ZONE_W-1:0] o_zone_lower_bound,
	output logic                            o_correlator_dc_path_enable,
	output logic      [lld_pkg::XRF_W-1:0]  o_extended_radio_select
);
	import lld_pkg::*;

	// Register state
	lld_bus_t           bus_r;
	logic [SEL_W-1:0]   probe_select_port0_r;
	logic               probe_enable_port0_r;
	logic [ZONE_W-1:0]  zone_upper_r;
	logic [ZONE_W-1:0]  zone_lower_r;
	logic [ERR_W-1:0]   err_r;
	logic [ERR_W-1:0]   err_nxt;
	logic [ERR_W-1:0]   mask_r;
	logic [DATA_W-1:0]  prof_r;
	logic               dcpath_r;
	logic [XRF_W-1:0]   xrf_r;
	logic [1:0]         run_r;
	logic [1:0]         run_nxt;
	logic [7:0]         lane0_nxt;
	logic [DATA_W-1:0]  rdata_nxt;

	// Bus decode: a request is served in the cycle that waitrequest is low
	wire                req      = i_read | i_write;
	wire                wr_take  = i_write & (bus_r == BUS_ANSWER);
	wire [DATA_W-1:0]   be_mask  = {{8{i_byteenable[3]}}, {8{i_byteenable[2]}},
	                                {8{i_byteenable[1]}}, {8{i_byteenable[0]}}};
	wire [DATA_W-1:0]   wmasked  = i_writedata & be_mask;
	wire                hit_ctrl = i_address == OFF_DIAG_CTRL;
	wire                hit_rdbk = i_address == OFF_DIAG_RDBK;
	wire                hit_upr  = i_address == OFF_ZONE_UPPER;
	wire                hit_lwr  = i_address == OFF_ZONE_LOWER;
	wire                hit_err  = i_address == OFF_ERR_FLAGS;
	wire                hit_prof = i_address == OFF_PROFILING;
	wire                hit_ists = i_address == OFF_IRQ_STATUS;
	wire                hit_imsk = i_address == OFF_IRQ_MASK;
	wire                hit_rc0  = i_address == OFF_RADIO_CTL0;
	wire                hit_rc1  = i_address == OFF_RADIO_CTL1;

	// Merge of written bytes into current contents
	function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_v,
	                                            input logic [DATA_W-1:0] m,
	                                            input logic [DATA_W-1:0] d);
		merge = (old_v & ~m) | d;
	endfunction

	wire [DATA_W-1:0]   ctrl_cur = {24'h00_0000, probe_enable_port0_r, 1'b0,
	                                probe_select_port0_r};
	wire [DATA_W-1:0]   ctrl_new = merge(ctrl_cur, be_mask, wmasked);
	wire [DATA_W-1:0]   upr_new  = merge({16'h0000, zone_upper_r}, be_mask, wmasked);
	wire [DATA_W-1:0]   lwr_new  = merge({16'h0000, zone_lower_r}, be_mask, wmasked);
	wire [DATA_W-1:0]   prof_new = merge(prof_r, be_mask, wmasked);
	wire [DATA_W-1:0]   msk_new  = merge({20'h0_0000, mask_r}, be_mask, wmasked);
	wire [DATA_W-1:0]   rc0_cur  = {9'h000, dcpath_r, RC0_RSVD_VAL};
	wire [DATA_W-1:0]   rc1_cur  = {11'h000, xrf_r, 16'h0000};
	wire [DATA_W-1:0]   rc0_new  = merge(rc0_cur, be_mask, wmasked);
	wire [DATA_W-1:0]   rc1_new  = merge(rc1_cur, be_mask, wmasked);

	// Write-one-to-clear, limited to written byte lanes and defined bits
	wire [ERR_W-1:0]    clr_bits = (wr_take & hit_ists) ?
	                               (wmasked[ERR_W-1:0] & ERR_MASK) : '0;

	// Live lane readback; lanes 1..3 come from elsewhere in the core
	wire [DATA_W-1:0]   rdbk_val = {i_debug_out_lane3, i_debug_out_lane2,
	                                i_debug_out_lane1, o_debug_out_lane0};

	// Channel-map population count, compared at hop start
	function automatic logic [CHCNT_W:0] popcount(input logic [CHMAP_BITS-1:0] v);
		logic [CHCNT_W:0] n;
		n = '0;
		for (int i = 0; i < CHMAP_BITS; i++)
			n = n + {{CHCNT_W{1'b0}}, v[i]};
		popcount = n;
	endfunction

	wire [CHCNT_W:0]    chan_cnt  = popcount(i_control_structure_channel_map);
	wire                chmap_bad = i_hop_start &
	                                (chan_cnt != {1'b0, i_good_channel_count});

	// Run of consecutive programmed exchange-table entries
	wire                run_hit = i_xtable_fetch & i_xtable_programmed &
	                              (run_r == PREFETCH_RUN - 2'h1);

	always_comb
	begin
		run_nxt = run_r;
		if (i_xtable_fetch)
			run_nxt = i_xtable_programmed ? (run_hit ? '0 : run_r + 2'h1) : '0;
	end

	// Event detection: each line except ev[9], which is tied to zero, is one error source
	wire [ERR_W-1:0]    ev;
	assign ev[ERR_TXCRYPT]  = i_payload_start & i_encrypt_busy;
	assign ev[ERR_PKTXMEM]  = i_packet_xmem_late;
	assign ev[ERR_TXDESC]   = i_tx_desc_fetch & ~i_descriptor_done_bit;
	assign ev[ERR_PREFETCH] = run_hit;
	assign ev[ERR_ACCLIST]  = i_accept_list_timeout;
	assign ev[ERR_RXCRYPT]  = i_ifs_expired & i_decrypt_busy;
	assign ev[ERR_IFS]      = i_ifs_expired &
	                          (i_cs_busy | i_accept_list_busy | i_decrypt_busy);
	assign ev[ERR_CHMAP]    = chmap_bad;
	assign ev[ERR_RADXMEM]  = i_radio_xmem_late;
	assign ev[9]            = 1'b0;
	assign ev[ERR_TXPTR]    = i_cs_fetch &
	                          (i_control_structure_tx_pointer == '0);
	assign ev[ERR_FORMAT]   = i_format_invalid;

	// Sticky flags: a new event beats a clear in the same cycle
	assign err_nxt = (err_r & ~clr_bits) | ev;

	// Diagnostic lane 0 source; disabled port drives zero
	always_comb
	begin
		lane0_nxt = 8'h00;
		if (probe_enable_port0_r)
		begin
			unique case (probe_select_port0_r)
				SEL_PROF0:  lane0_nxt = prof_r[7:0];
				SEL_PROF1:  lane0_nxt = prof_r[15:8];
				SEL_PROF2:  lane0_nxt = prof_r[23:16];
				SEL_PROF3:  lane0_nxt = prof_r[31:24];
				SEL_ERR_LO: lane0_nxt = err_r[7:0];
				SEL_ERR_HI: lane0_nxt = {4'h0, err_r[11:8]};
				default:    lane0_nxt = 8'h00;
			endcase
		end
	end

	// Read mux; unmapped addresses read zero
	always_comb
	begin
		rdata_nxt = '0;
		unique case (1'b1)
			hit_ctrl: rdata_nxt = ctrl_cur;
			hit_rdbk: rdata_nxt = rdbk_val;
			hit_upr:  rdata_nxt = {16'h0000, zone_upper_r};
			hit_lwr:  rdata_nxt = {16'h0000, zone_lower_r};
			hit_err:  rdata_nxt = {20'h0_0000, err_r};
			hit_prof: rdata_nxt = prof_r;
			hit_ists: rdata_nxt = {20'h0_0000, err_r};
			hit_imsk: rdata_nxt = {20'h0_0000, mask_r};
			hit_rc0:  rdata_nxt = rc0_cur;
			hit_rc1:  rdata_nxt = rc1_cur;
			default:  rdata_nxt = '0;
		endcase
	end

	// Handshake: one wait cycle, then answer for exactly one cycle
	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			bus_r         <= BUS_IDLE;
			o_waitrequest <= 1'b1;
			o_readdata    <= '0;
		end
		else
		begin
			bus_r         <= (bus_r == BUS_IDLE && req) ? BUS_ANSWER : BUS_IDLE;
			o_waitrequest <= !(bus_r == BUS_IDLE && req);
			o_readdata    <= (bus_r == BUS_IDLE && i_read) ? rdata_nxt : '0;
		end
	end

	// Software-written control fields
	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			probe_select_port0_r <= '0;
			probe_enable_port0_r <= 1'b0;
			zone_upper_r         <= '0;
			zone_lower_r         <= '0;
			prof_r               <= '0;
			mask_r               <= '0;
		end
		else if (wr_take)
		begin
			if (hit_ctrl)
			begin
				probe_select_port0_r <= ctrl_new[SEL_LSB +: SEL_W];
				probe_enable_port0_r <= ctrl_new[EN0_BIT];
			end
			if (hit_upr)
				zone_upper_r <= upr_new[ZONE_W-1:0];
			if (hit_lwr)
				zone_lower_r <= lwr_new[ZONE_W-1:0];
			if (hit_prof)
				prof_r <= prof_new;
			if (hit_imsk)
				mask_r <= msk_new[ERR_W-1:0] & ERR_MASK;
		end
	end

	// Radio control: only the two documented fields hold state
	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			dcpath_r <= 1'b0;
			xrf_r    <= '0;
		end
		else if (wr_take)
		begin
			if (hit_rc0)
				dcpath_r <= rc0_new[DCPATH_BIT];
			if (hit_rc1)
				xrf_r <= rc1_new[XRF_LSB +: XRF_W];
		end
	end

	// Error flags, prefetch run counter and interrupt
	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			err_r <= '0;
			run_r <= '0;
			o_irq <= 1'b0;
		end
		else
		begin
			err_r <= err_nxt;
			run_r <= run_nxt;
			o_irq <= |(err_nxt & mask_r);
		end
	end

	// Registered outputs towards the diagnostic port and radio
	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_debug_out_lane0           <= 8'h00;
			o_profiling_value           <= '0;
			o_zone_upper_bound          <= '0;
			o_zone_lower_bound          <= '0;
			o_correlator_dc_path_enable <= 1'b0;
			o_extended_radio_select     <= '0;
		end
		else
		begin
			o_debug_out_lane0           <= lane0_nxt;
			o_profiling_value           <= prof_r;
			o_zone_upper_bound          <= zone_upper_r;
			o_zone_lower_bound          <= zone_lower_r;
			o_correlator_dc_path_enable <= dcpath_r;
			o_extended_radio_select     <= xrf_r;
		end
	end

	// Checks; held-request helper sequences
	sequence wr_req_s(logic [31:0] a);
		i_write && i_address == a && i_byteenable == 4'hF && o_waitrequest;
	endsequence
	sequence done_s;
		!o_waitrequest;
	endsequence

	lane_off_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		!probe_enable_port0_r |=> o_debug_out_lane0 == 8'h00)
		else $error("lane 0 not zero while disabled");

	lane_sel_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		probe_enable_port0_r && probe_select_port0_r == SEL_PROF0
		|=> o_debug_out_lane0 == $past(prof_r[7:0]))
		else $error("lane 0 select mismatch");

	rdbk_live_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		i_read && hit_rdbk && o_waitrequest && bus_r == BUS_IDLE
		|=> o_readdata == {$past(i_debug_out_lane3), $past(i_debug_out_lane2),
		                   $past(i_debug_out_lane1), $past(o_debug_out_lane0)})
		else $error("readback not live lanes");

	zone_write_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		wr_req_s(OFF_ZONE_UPPER) ##1 done_s
		|=> zone_upper_r == $past(i_writedata[15:0]))
		else $error("zone upper not written");

	txptr_flag_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		i_cs_fetch && i_control_structure_tx_pointer == '0 |=> err_r[ERR_TXPTR])
		else $error("null pointer flag not set");

	chmap_flag_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		i_hop_start && chan_cnt != {1'b0, i_good_channel_count} |=> err_r[ERR_CHMAP])
		else $error("channel map flag not set");

	ifs_flag_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		i_ifs_expired && i_cs_busy |=> err_r[ERR_IFS])
		else $error("frame space underrun not flagged");

	prefetch_run_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(i_xtable_fetch && i_xtable_programmed)[*3] |=> err_r[ERR_PREFETCH])
		else $error("prefetch fault not flagged");

	desc_flag_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		i_tx_desc_fetch && !i_descriptor_done_bit |=> err_r[ERR_TXDESC])
		else $error("descriptor fault not flagged");

	encrypt_flag_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		i_payload_start && i_encrypt_busy |=> err_r[ERR_TXCRYPT])
		else $error("encrypt late not flagged");

	err_sticky_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		err_r[ERR_FORMAT] && !(wr_take && hit_ists) |=> err_r[ERR_FORMAT])
		else $error("error flag dropped without clear");

	ro_ignore_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		wr_take && hit_err && ev == '0 |=> err_r == $past(err_r))
		else $error("write changed read-only flags");

	prof_copy_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		##1 o_profiling_value == $past(prof_r))
		else $error("profiling word not copied");
endmodule

// ---- dv/lld_tb.sv ----
// Self-checking bench for the link-layer diagnostic and error register bank.
// Assumes lld_pkg is compiled first; drives every port of lld_regs directly.
`timescale 1ns/1ps
module tb;
	import lld_pkg::*;
	typedef struct packed {logic [31:0] a, rs, wd; logic [3:0] be; logic [31:0] rd;} lld_row_t;
	localparam logic [31:0] PROF = 32'hA5C3_1E77;
	logic        sys_clk, rst_n, rd_q, wr_q;
	logic [31:0] addr, wdata, o_readdata, o_profiling_value, q;
	logic [3:0]  ben;
	logic        o_waitrequest, o_irq, xprog, csb, alb, decb, done, encb, o_dc_en;
	logic [15:0] ptr, o_zone_upper, o_zone_lower;
	logic [36:0] chmap;
	logic [5:0]  cnt;
	logic [9:0]  pv;
	logic [7:0]  lane1, lane2, lane3, o_lane0;
	logic [4:0]  o_xrf;
	logic [11:0] ex [18];
	int          pid [18];
	lld_row_t    rows [11];
	int          err_total, compares;
	lld_regs uut (.i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_address(addr), .i_read(rd_q),
		.i_write(wr_q), .i_writedata(wdata), .i_byteenable(ben), .o_readdata(o_readdata),
		.o_waitrequest(o_waitrequest), .o_irq(o_irq), .i_format_invalid(pv[0]),
		.i_cs_fetch(pv[1]), .i_control_structure_tx_pointer(ptr), .i_radio_xmem_late(pv[2]),
		.i_hop_start(pv[3]), .i_control_structure_channel_map(chmap),
		.i_good_channel_count(cnt), .i_ifs_expired(pv[4]), .i_cs_busy(csb),
		.i_accept_list_busy(alb), .i_decrypt_busy(decb), .i_accept_list_timeout(pv[5]),
		.i_xtable_fetch(pv[6]), .i_xtable_programmed(xprog), .i_tx_desc_fetch(pv[7]),
		.i_descriptor_done_bit(done), .i_packet_xmem_late(pv[8]), .i_payload_start(pv[9]),
		.i_encrypt_busy(encb), .i_debug_out_lane1(lane1), .i_debug_out_lane2(lane2),
		.i_debug_out_lane3(lane3), .o_debug_out_lane0(o_lane0),
		.o_profiling_value(o_profiling_value), .o_zone_upper_bound(o_zone_upper),
		.o_zone_lower_bound(o_zone_lower), .o_correlator_dc_path_enable(o_dc_en),
		.o_extended_radio_select(o_xrf));
	// Free-running 50 MHz clock
	initial
	begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	task automatic stop_test();
		if (err_total == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e)
		begin
			err_total++;
			$display("unexpected at %0t got %h exp %h", $time, g, e);
		end
	endtask
	// One Avalon transfer; request held until waitrequest is sampled low
	task automatic xfer(input logic we, input logic [31:0] a, input logic [31:0] d,
		input logic [3:0] be, output logic [31:0] rv);
		int t;
		t = 0;
		@(posedge sys_clk);
		addr <= a;
		wdata <= d;
		ben <= be;
		wr_q <= we;
		rd_q <= !we;
		do
		begin
			@(posedge sys_clk);
			t++;
		end
		while (o_waitrequest !== 1'b0 && t < 50);
		rv = o_readdata;
		wr_q <= 1'b0;
		rd_q <= 1'b0;
		if (t >= 50)
		begin
			err_total++;
			stop_test();
		end
	endtask
	task automatic w(input logic [31:0] a, input logic [31:0] d);
		xfer(1'b1, a, d, 4'hF, q);
	endtask
	task automatic r(input logic [31:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0000_0000, 4'hF, q);
		chk(q, e);
	endtask
	task automatic settle();
		repeat (3) @(posedge sys_clk);
	endtask
	// Set the qualifying levels for case k, then pulse its event line
	task automatic fire(input int k);
		int n;
		n = (k == 10 || k == 11) ? 3 : 1;
		@(posedge sys_clk);
		ptr <= (k == 2) ? 16'h0005 : 16'h0000;
		cnt <= (k == 5) ? 6'h03 : 6'h02;
		csb <= (k == 6);
		decb <= (k == 7);
		alb <= (k == 17);
		xprog <= 1'b1;
		done <= (k == 13);
		encb <= (k == 15);
		// Multi-fetch cases hold the strobe on back-to-back cycles
		for (int i = 0; i < n; i++)
		begin
			@(posedge sys_clk);
			if (k == 10 && i == 2)
				xprog <= 1'b0;
			pv <= 10'h001 << pid[k];
		end
		@(posedge sys_clk);
		pv <= 10'h000;
		settle();
	endtask
	// Watchdog well beyond the several hundred cycles the tests need
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		err_total++;
		stop_test();
	end
	initial
	begin
		{rd_q, wr_q, addr, wdata, ben, pv, ptr, cnt, csb, alb, decb, done, encb} = '0;
		{xprog, lane1, lane2, lane3} = '0;
		chmap = 37'h00_0000_0007;
		err_total = 0;
		compares = 0;
		rst_n = 1'b0;
		ex = '{12'h800, 12'h400, 12'h000, 12'h100, 12'h080, 12'h000, 12'h040, 12'h060, 12'h000,
			12'h010, 12'h000, 12'h008, 12'h004, 12'h000, 12'h002, 12'h001, 12'h000, 12'h040};
		pid = '{0, 1, 1, 2, 3, 3, 4, 4, 4, 5, 6, 6, 7, 7, 8, 9, 9, 4};
		rows = '{'{OFF_DIAG_CTRL, 32'h0, 32'hFFFF_FFFF, 4'hF, 32'h0000_00BF},
			'{OFF_DIAG_RDBK, 32'h0, 32'hFFFF_FFFF, 4'hF, 32'h0},
			'{OFF_ZONE_UPPER, 32'h0, 32'hFFFF_1234, 4'hF, 32'h0000_1234},
			'{OFF_ZONE_LOWER, 32'h0, 32'hFFFF_FFAB, 4'h1, 32'h0000_00AB},
			'{OFF_ERR_FLAGS, 32'h0, 32'hFFFF_FFFF, 4'hF, 32'h0},
			'{OFF_PROFILING, 32'h0, PROF, 4'hF, PROF},
			'{OFF_RADIO_CTL0, 32'h0000_2102, 32'hFFFF_FFFF, 4'hF, 32'h0040_2102},
			'{OFF_RADIO_CTL1, 32'h0, 32'hFFFF_FFFF, 4'hF, 32'h001F_0000},
			'{OFF_IRQ_MASK, 32'h0, 32'hFFFF_FFFF, 4'hF, 32'h0000_0DFF},
			'{32'h4000_0078, 32'h0, 32'hFFFF_FFFF, 4'hF, 32'h0},
			'{OFF_IRQ_STATUS, 32'h0, 32'hFFFF_FFFF, 4'hF, 32'h0}};
		repeat (5) @(posedge sys_clk);
		rst_n <= 1'b1;
		// Reset value, write, read back for every row
		foreach (rows[i])
		begin
			r(rows[i].a, rows[i].rs);
			xfer(1'b1, rows[i].a, rows[i].wd, rows[i].be, q);
			r(rows[i].a, rows[i].rd);
		end
		settle();
		chk({o_zone_upper, o_zone_lower}, 32'h1234_00AB);
		chk(o_profiling_value, PROF);
		chk({26'h0, o_dc_en, o_xrf}, 32'h0000_003F);
		// Lane 0 selection of profiling bytes and live readback of all lanes
		lane1 <= 8'h11;
		lane2 <= 8'h22;
		lane3 <= 8'h33;
		for (int s = 0; s < 4; s++)
		begin
			w(OFF_DIAG_CTRL, 32'h0000_0080 | 32'(s));
			settle();
			chk({24'h0, o_lane0}, {24'h0, PROF[8*s +: 8]});
			r(OFF_DIAG_RDBK, {24'h33_2211, PROF[8*s +: 8]});
		end
		w(OFF_DIAG_CTRL, 32'h0000_0001);
		settle();
		chk({24'h0, o_lane0}, 32'h0);
		r(OFF_DIAG_RDBK, 32'h3322_1100);
		// Each error source alone, with flag, interrupt and clear checked
		for (int k = 0; k < 18; k++)
		begin
			fire(k);
			r(OFF_ERR_FLAGS, {20'h0, ex[k]});
			r(OFF_IRQ_STATUS, {20'h0, ex[k]});
			chk({31'h0, o_irq}, {31'h0, ex[k] != 12'h0});
			w(OFF_IRQ_STATUS, 32'h0000_0FFF);
			settle();
			r(OFF_ERR_FLAGS, 32'h0);
			chk({31'h0, o_irq}, 32'h0);
		end
		// Flags routed onto lane 0
		fire(0);
		fire(4);
		w(OFF_DIAG_CTRL, 32'h0000_0084);
		settle();
		chk({24'h0, o_lane0}, 32'h0000_0080);
		w(OFF_DIAG_CTRL, 32'h0000_0085);
		settle();
		chk({24'h0, o_lane0}, 32'h0000_0008);
		w(OFF_IRQ_STATUS, 32'h0000_0FFF);
		// Masked flag raises no interrupt until unmasked
		w(OFF_IRQ_MASK, 32'h0000_07FF);
		fire(0);
		chk({31'h0, o_irq}, 32'h0);
		r(OFF_ERR_FLAGS, 32'h0000_0800);
		w(OFF_IRQ_MASK, 32'h0000_0FFF);
		settle();
		chk({31'h0, o_irq}, 32'h1);
		// Event on the clearing edge must survive the clear
		fork
			w(OFF_IRQ_STATUS, 32'h0000_0FFF);
			begin
				@(negedge sys_clk iff wr_q === 1'b1);
				@(posedge sys_clk);
				pv <= 10'h001;
				@(posedge sys_clk);
				pv <= 10'h000;
			end
		join
		settle();
		r(OFF_ERR_FLAGS, 32'h0000_0800);
		w(OFF_IRQ_STATUS, 32'h0000_0FFF);
		// Mandatory radio settings kept by software
		w(OFF_RADIO_CTL0, 32'h0000_0000);
		w(OFF_RADIO_CTL1, 32'h0003_0000);
		settle();
		chk({26'h0, o_dc_en, o_xrf}, 32'h0000_0003);
		// Second reset in mid-run returns registers to their reset values
		@(posedge sys_clk);
		rst_n <= 1'b0;
		settle();
		chk({31'h0, o_waitrequest}, 32'h1);
		chk(o_profiling_value, 32'h0);
		rst_n <= 1'b1;
		r(OFF_PROFILING, 32'h0);
		r(OFF_RADIO_CTL0, 32'h0000_2102);
		stop_test();
	end
endmodule
